// ==== rtl/pcm_port_params.svh ====
// constants of the voiceband serial audio port
`ifndef PCM_PORT_PARAMS_SVH
`define PCM_PORT_PARAMS_SVH

// bit clock rate in the voiceband format, kHz
`define VB_BCLK_KHZ      2048
// frame rate, kHz (125 us frame period)
`define VB_FRAME_KHZ     8
`define VB_FRAME_US      125
// bit clocks per frame, derived
`define VB_BITS_PER_FRM  (`VB_BCLK_KHZ / `VB_FRAME_KHZ)
// serial word layout
`define VB_WORD_BITS     16
`define VB_SAMPLE_BITS   13
`define VB_PAD_BITS      3
// first and last data bit slot, counted in bit clocks from the sync slot
`define VB_FIRST_SLOT    8'h01
`define VB_LAST_SLOT     8'h10
`define VB_SYNC_SLOT     8'h00
// default link reference clock, kHz (12 ns period)
`define LINK_REF_KHZ_DEF 83333
// reset value of the frame position so that the first bit clock lands on the sync slot
`define VB_SLOT_RESET    8'hff

`endif

// ==== rtl/pcm_pkg.sv ====
// types shared by the voiceband serial audio port
package pcm_pkg;

	// selectable data formats; only the voiceband one is timed by this port
	typedef enum logic [1:0] {
		FMT_VOICE,
		FMT_STEREO_A,
		FMT_STEREO_B,
		FMT_STEREO_C
	} fmt_t;

	// position of the link within a frame
	typedef enum logic [1:0] {
		LS_OFF,
		LS_SYNC,
		LS_DATA,
		LS_QUIET
	} link_st_t;

	// outgoing pin group of the port
	typedef struct packed {
		logic bclk;
		logic voice_frame_sync;
		logic dout;
		logic dout_oe_n;
	} pcm_out_t;

endpackage

// ==== rtl/cdc_sync.sv ====
// two-flop level synchroniser, one per bit
`timescale 1ns/1ps

module cdc_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_r;

	// the first stage feeds only the second stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule

// ==== rtl/voiceband_pcm_master_port.sv ====
// voiceband serial audio port, bus master side
//
// Overview of operation
// - device generates bit clock and frame sync
// - four lines: clock, sync, data out, in
// - samples are linear two's complement both ways
// - four formats: voiceband plus three stereo; only voiceband is run here, the stereo ones just raise fmt_unsupported
// - voiceband bit clock runs continuously, 2048 kHz
// - sync one bit clock wide, every 125 us
// - 13 sample bits plus 3 zero bits
// - 16 bits both ways after sync fall
// - no data after 16 bits until sync
// - data driver high impedance while inactive
`timescale 1ns/1ps
`include "pcm_port_params.svh"

module voiceband_pcm_master_port
	import pcm_pkg::*;
#(
	parameter int REF_KHZ = `LINK_REF_KHZ_DEF
) (
	input  wire logic                        clk,
	input  wire logic                        rst,
	input  wire logic                        link_clk,
	input  wire logic                        port_en,
	input  wire fmt_t                        fmt_sel,
	input  wire logic [`VB_SAMPLE_BITS-1:0]  tx_sample,
	input  wire logic                        tx_load,
	output logic                             tx_ready,
	output logic      [`VB_SAMPLE_BITS-1:0]  rx_sample,
	output logic                             rx_valid,
	output logic                             fmt_unsupported,
	output pcm_out_t                         pcm_out,
	input  wire logic                        pcm_din
);

	localparam logic [17:0] ACC_STEP = 18'(2 * `VB_BCLK_KHZ);
	localparam logic [17:0] ACC_MOD  = 18'(REF_KHZ);
	localparam logic [`VB_PAD_BITS-1:0] PAD_ZERO = '0;

	// ---------------- system clock side ----------------

	logic [`VB_SAMPLE_BITS-1:0] tx_hold_r;
	logic                       tx_req_tgl_r;
	logic                       tx_ready_r;
	logic [`VB_SAMPLE_BITS-1:0] rx_sample_r;
	logic                       rx_valid_r;
	logic                       rx_seen_r;
	logic [`VB_SAMPLE_BITS-1:0] rx_hold_r;
	logic                       fmt_unsup_r;
	logic                       tx_ack_s;
	logic                       rx_tgl_s;

	wire tx_take     = tx_load & tx_ready_r;
	wire tx_idle_hs  = (tx_ack_s == tx_req_tgl_r);
	wire rx_new      = (rx_tgl_s != rx_seen_r);
	wire fmt_bad     = port_en & (fmt_sel != FMT_VOICE);

	// sample word is held still until the link side has acknowledged it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_hold_r    <= '0;
			tx_req_tgl_r <= 1'b0;
			tx_ready_r   <= 1'b0;
		end else begin
			if (tx_take) begin
				tx_hold_r    <= tx_sample;
				tx_req_tgl_r <= ~tx_req_tgl_r;
			end
			tx_ready_r <= tx_idle_hs & ~tx_take;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_seen_r   <= 1'b0;
			rx_sample_r <= '0;
			rx_valid_r  <= 1'b0;
			fmt_unsup_r <= 1'b0;
		end else begin
			rx_seen_r  <= rx_tgl_s;
			rx_valid_r <= rx_new;
			if (rx_new) begin
				rx_sample_r <= rx_hold_r;
			end
			fmt_unsup_r <= fmt_bad;
		end
	end

	assign tx_ready        = tx_ready_r;
	assign rx_sample       = rx_sample_r;
	assign rx_valid        = rx_valid_r;
	assign fmt_unsupported = fmt_unsup_r;

	// ---------------- link clock side ----------------

	logic        lrst_meta_r;
	logic        lrst_r;
	logic        en_l;
	fmt_t        fmt_l;
	logic [1:0]  fmt_raw_l;
	logic        tx_req_l;
	logic        din_l;

	logic [17:0]                acc_r;
	logic                       bclk_r;
	logic [7:0]                 slot_r;
	link_st_t                   st_r;
	logic                       fsync_r;
	logic                       dout_r;
	logic                       oe_n_r;
	logic [`VB_WORD_BITS-1:0]   tx_shift_r;
	logic [`VB_SAMPLE_BITS-1:0] tx_word_r;
	logic                       tx_ack_r;
	logic [`VB_WORD_BITS-1:0]   rx_shift_r;
	logic                       rx_tgl_r;
	logic [1:0]                 fall_d_r;

	// the link side leaves reset on its own clock
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			lrst_meta_r <= 1'b1;
			lrst_r      <= 1'b1;
		end else begin
			lrst_meta_r <= 1'b0;
			lrst_r      <= lrst_meta_r;
		end
	end

	// format select is quasi-static: change it only while the port is disabled
	cdc_sync #(.W(5)) u_to_link (
		.clk (link_clk),
		.rst (lrst_r),
		.d   ({port_en, fmt_sel, tx_req_tgl_r, pcm_din}),
		.q   ({en_l, fmt_raw_l, tx_req_l, din_l})
	);

	cdc_sync #(.W(2)) u_to_sys (
		.clk (clk),
		.rst (rst),
		.d   ({tx_ack_r, rx_tgl_r}),
		.q   ({tx_ack_s, rx_tgl_s})
	);

	assign fmt_l = fmt_t'(fmt_raw_l);

	// fractional divider: toggles average out to exactly 4096 kHz, a 2048 kHz bit clock, on any reference from 4096 to 258048 kHz
	wire [17:0] acc_sum  = acc_r + ACC_STEP;
	wire        acc_wrap = (acc_sum >= ACC_MOD);
	wire [17:0] acc_nxt  = acc_wrap ? (acc_sum - ACC_MOD) : acc_sum;
	// the stereo formats have no timing here, so the port stays quiet in them
	wire        run      = en_l & (fmt_l == FMT_VOICE);
	wire        rise     = run & acc_wrap & ~bclk_r;
	wire        fall     = acc_wrap & bclk_r;
	wire [7:0]  slot_nxt = slot_r + 8'h01;

	wire        sync_nxt = (slot_nxt == `VB_SYNC_SLOT);
	wire        data_nxt = (slot_nxt >= `VB_FIRST_SLOT) &&
	                       (slot_nxt <= `VB_LAST_SLOT);
	wire        first_nxt = (slot_nxt == `VB_FIRST_SLOT);
	wire [`VB_WORD_BITS-1:0] tx_word_full = {tx_word_r, PAD_ZERO};
	wire [`VB_WORD_BITS-1:0] tx_src = first_nxt ? tx_word_full : tx_shift_r;
	wire [`VB_WORD_BITS-1:0] rx_shifted = {rx_shift_r[`VB_WORD_BITS-2:0], din_l};
	wire        rx_sample_pt = fall_d_r[1] & (st_r == LS_DATA);
	wire        rx_last      = rx_sample_pt & (slot_r == `VB_LAST_SLOT);
	wire        tx_new       = (tx_req_l != tx_ack_r);

	link_st_t st_nxt;
	always_comb begin
		st_nxt = st_r;
		if (!run) begin
			st_nxt = LS_OFF;
		end else if (rise) begin
			if (sync_nxt) begin
				st_nxt = LS_SYNC;
			end else if (data_nxt) begin
				st_nxt = LS_DATA;
			end else begin
				st_nxt = LS_QUIET;
			end
		end
	end

	// bit clock runs free while the voiceband format is enabled
	always_ff @(posedge link_clk or posedge lrst_r) begin
		if (lrst_r) begin
			acc_r  <= '0;
			bclk_r <= 1'b0;
		end else if (!run && !bclk_r) begin
			acc_r <= '0;
		end else begin
			acc_r <= acc_nxt;
			if (acc_wrap) begin
				bclk_r <= ~bclk_r;
			end
		end
	end

	// frame position and pin drive, all moved on the rising bit clock edge
	always_ff @(posedge link_clk or posedge lrst_r) begin
		if (lrst_r) begin
			slot_r     <= `VB_SLOT_RESET;
			st_r       <= LS_OFF;
			fsync_r    <= 1'b0;
			dout_r     <= 1'b0;
			oe_n_r     <= 1'b1;
			tx_shift_r <= '0;
		end else begin
			st_r <= st_nxt;
			if (!run) begin
				slot_r  <= `VB_SLOT_RESET;
				fsync_r <= 1'b0;
				dout_r  <= 1'b0;
				oe_n_r  <= 1'b1;
			end else if (rise) begin
				slot_r  <= slot_nxt;
				fsync_r <= sync_nxt;
				dout_r  <= data_nxt & tx_src[`VB_WORD_BITS-1];
				oe_n_r  <= ~data_nxt;
				tx_shift_r <= {tx_src[`VB_WORD_BITS-2:0], 1'b0};
			end
		end
	end

	// a new sample is picked up between words; without one the last is repeated
	always_ff @(posedge link_clk or posedge lrst_r) begin
		if (lrst_r) begin
			tx_word_r <= '0;
			tx_ack_r  <= 1'b0;
		end else if (tx_new && !(st_r == LS_DATA)) begin
			tx_word_r <= tx_hold_r;
			tx_ack_r  <= tx_req_l;
		end
	end

	// input is read two reference cycles after the falling bit clock edge,
	// which covers the synchroniser delay and stays well inside the bit
	always_ff @(posedge link_clk or posedge lrst_r) begin
		if (lrst_r) begin
			fall_d_r   <= '0;
			rx_shift_r <= '0;
			rx_hold_r  <= '0;
			rx_tgl_r   <= 1'b0;
		end else begin
			fall_d_r <= {fall_d_r[0], fall};
			if (rx_sample_pt) begin
				rx_shift_r <= rx_shifted;
			end
			if (rx_last) begin
				rx_hold_r <= rx_shifted[`VB_WORD_BITS-1:`VB_PAD_BITS];
				rx_tgl_r  <= ~rx_tgl_r;
			end
		end
	end

	// four pins, all straight from flops
	assign pcm_out.bclk             = bclk_r;
	assign pcm_out.voice_frame_sync = fsync_r;
	assign pcm_out.dout             = dout_r;
	assign pcm_out.dout_oe_n        = oe_n_r;

endmodule

// ==== dv/voiceband_pcm_master_port_props.sv ====
// pin-level assertions for the voiceband serial audio port
`timescale 1ns/1ps
module voiceband_pcm_master_port_props
	import pcm_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        link_clk,
	input wire logic        port_en,
	input wire fmt_t        fmt_sel,
	input wire logic        tx_load,
	input wire logic        tx_ready,
	input wire logic [12:0] rx_sample,
	input wire logic        rx_valid,
	input wire logic        fmt_unsupported,
	input wire pcm_out_t    pcm_out
);
	wire bk = pcm_out.bclk;
	wire fs = pcm_out.voice_frame_sync;
	wire dq = pcm_out.dout;
	wire oe = pcm_out.dout_oe_n;
	chk_sync_one_wide: assert property (@(posedge bk) disable iff (rst)
		fs |=> !fs) else $error("sync too wide");
	chk_data_slots: assert property (@(posedge bk) disable iff (rst)
		fs |=> !oe[*8] ##1 !oe[*8] ##1 oe) else $error("data window wrong");
	chk_pad_zero: assert property (@(posedge bk) disable iff (rst)
		fs |-> oe ##14 !dq ##1 !dq ##1 !dq) else $error("pad bits not zero");
	// launch on the link edge that raises the bit clock, so the far end has half a period
	chk_edge_launch: assert property (@(posedge link_clk) disable iff (rst)
		$changed(dq) || $changed(fs) |-> $rose(bk)) else $error("launch off edge");
	chk_flag_stereo: assert property (@(posedge clk) disable iff (rst)
		port_en && fmt_sel != FMT_VOICE |=> fmt_unsupported) else $error("flag missing");
	chk_stereo_idle: assert property (@(posedge clk) disable iff (rst)
		fmt_unsupported |-> oe && !fs) else $error("pins active in stereo");
	chk_rx_single: assert property (@(posedge clk) disable iff (rst)
		rx_valid |=> !rx_valid[*8]) else $error("rx pulse repeats");
	chk_rx_hold: assert property (@(posedge clk) disable iff (rst)
		!rx_valid |-> $stable(rx_sample)) else $error("rx sample moved");
	chk_load_taken: assert property (@(posedge clk) disable iff (rst)
		tx_load && tx_ready |=> !tx_ready) else $error("load not taken");
endmodule

bind voiceband_pcm_master_port voiceband_pcm_master_port_props props_i (
	.clk(clk), .rst(rst), .link_clk(link_clk), .port_en(port_en), .fmt_sel(fmt_sel),
	.tx_load(tx_load), .tx_ready(tx_ready), .rx_sample(rx_sample), .rx_valid(rx_valid),
	.fmt_unsupported(fmt_unsupported), .pcm_out(pcm_out)
);

// ==== dv/pcm_codec_model.sv ====
// behavioural codec at the far end of the voiceband port
`timescale 1ns/1ps
module pcm_codec_model
	import pcm_pkg::*;
(
	input  wire pcm_out_t    pins,
	input  wire logic [12:0] smp,
	output logic             din,
	output logic [15:0]      got,
	output int               len
);
	wire  [15:0] wd = {smp, 3'h0};
	logic [15:0] sh = '0;
	int          cnt = 300;
	initial din = 1'b0;
	// sync and data are read on the falling edge only, away from the launching edge
	always @(negedge pins.bclk) begin
		if (pins.voice_frame_sync) begin
			len = cnt + 1;
			cnt = 0;
		end else begin
			cnt++;
			if (cnt <= 16) begin
				sh = {sh[14:0], pins.dout};
				got = sh;
			end
		end
	end
	always @(posedge pins.bclk) begin
		if (cnt < 16)
			din <= wd[15 - cnt];
		else
			din <= ~din; // released: toggles so a stale bit cannot pass
	end
endmodule

// ==== dv/tb_voiceband_pcm_master_port.sv ====
// self-checking bench for the voiceband serial audio port
`timescale 1ns/1ps
module tb_voiceband_pcm_master_port
	import pcm_pkg::*;
;
	typedef struct {
		logic [12:0] tx;
		logic [12:0] rx;
	} row_t;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        link_clk = 1'b0;
	logic        port_en = 1'b0;
	fmt_t        fmt_sel = FMT_VOICE;
	logic [12:0] tx_sample = '0;
	logic        tx_load = 1'b0;
	logic [12:0] cod_smp = '0;
	logic        tx_ready;
	logic [12:0] rx_sample;
	logic        rx_valid;
	logic        fmt_unsupported;
	pcm_out_t    pcm_out;
	logic        pcm_din;
	logic [15:0] got;
	int          len;
	int          num_errors = 0;
	int          num_checks = 0;
	int          nb = 0;
	int          b;
	realtime     t0;
	realtime     d;
	row_t        rows [3] = '{'{13'h1000, 13'h0fff}, '{13'h0001, 13'h1fff},
		'{13'h1555, 13'h0aaa}};

	always #2.5 clk = ~clk;
	initial begin
		#1.3;
		forever #6 link_clk = ~link_clk;
	end
	always @(posedge pcm_out.bclk) nb++;

	voiceband_pcm_master_port #(.REF_KHZ(83333)) dut (
		.clk(clk), .rst(rst), .link_clk(link_clk), .port_en(port_en), .fmt_sel(fmt_sel),
		.tx_sample(tx_sample), .tx_load(tx_load), .tx_ready(tx_ready),
		.rx_sample(rx_sample), .rx_valid(rx_valid), .fmt_unsupported(fmt_unsupported),
		.pcm_out(pcm_out), .pcm_din(pcm_din)
	);
	pcm_codec_model cod (.pins(pcm_out), .smp(cod_smp), .din(pcm_din), .got(got), .len(len));

	task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wt(input bit rdy);
		int k;
		k = 0;
		do begin
			@(posedge clk);
			#1;
			k++;
		end while ((rdy ? tx_ready : rx_valid) !== 1'b1 && k < 30000);
		cmp("wait", 16'h1, {15'h0, k < 30000});
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge clk);
		#1;
		rst = 1'b0;
		port_en = 1'b1;
		wt(0);
		t0 = $realtime;
		foreach (rows[i]) begin
			cmp("ready", 16'h1, {15'h0, tx_ready});
			tx_sample = rows[i].tx;
			cod_smp = rows[i].rx;
			tx_load = 1'b1;
			@(posedge clk);
			#1;
			tx_load = 1'b0;
			cmp("ready", 16'h0, {15'h0, tx_ready});
			wt(1);
			wt(0);
			d = $realtime - t0;
			t0 = $realtime;
			cmp("period", 16'h1, {15'h0, d > 124960.0 && d < 125040.0});
			cmp("len", 16'd256, len[15:0]);
			cmp("rx", {3'h0, rows[i].rx}, {3'h0, rx_sample});
			cmp("tx", {rows[i].tx, 3'h0}, got);
			cmp("flag", 16'h0, {15'h0, fmt_unsupported});
		end
		port_en = 1'b0;
		for (int f = 1; f < 4; f++) begin
			fmt_sel = fmt_t'(f);
			repeat (200) @(posedge clk);
			#1;
			b = nb;
			port_en = 1'b1;
			repeat (20) @(posedge clk);
			#1;
			cmp("flag", 16'h1, {15'h0, fmt_unsupported});
			cmp("bclk", b[15:0], nb[15:0]);
			port_en = 1'b0;
		end
		rst = 1'b1;
		#1;
		cmp("rst", 16'h1, {9'h0, tx_ready, rx_valid, fmt_unsupported, pcm_out});
		cmp("rst_rx", 16'h0, {3'h0, rx_sample});
		wrap_up();
	end

	initial begin
		#450us;
		num_errors++;
		wrap_up();
	end
endmodule
